//--- core/otp_prog_pkg.sv
/*
 * Shared constants and state types for the parallel one-time PROM programmer.
 * Assumes a single 20 MHz system clock and a PROM-mode target socket.
 */
package otp_prog_pkg;

    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned ADDR_W         = 15;

    // program strobe width, nominal 0.1 ms
    localparam int unsigned PULSE_NS       = 100000;
    localparam int unsigned PULSE_CYC      = PULSE_NS / CLK_PERIOD_NS;
    // setup / hold / turnaround around every strobe, gate and data-bus change
    localparam int unsigned SETTLE_NS      = 1000;
    localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // wait after applying mode-setting levels before the first cycle
    localparam int unsigned MODE_NS        = 10000;
    localparam int unsigned MODE_CYC       = (MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W          = 12;

    localparam int unsigned MAX_PULSES     = 25;
    localparam int unsigned TRY_W          = 5;

    // image size codes and PROM-mode start addresses; range always ends at 7fff
    localparam logic [1:0]        SIZE_32K   = 2'h0;
    localparam logic [1:0]        SIZE_16K   = 2'h1;
    localparam logic [1:0]        SIZE_8K    = 2'h2;
    localparam logic [1:0]        SIZE_4K    = 2'h3;
    localparam logic [ADDR_W-1:0] START_32K  = 15'h0000;
    localparam logic [ADDR_W-1:0] START_16K  = 15'h4000;
    localparam logic [ADDR_W-1:0] START_8K   = 15'h6000;
    localparam logic [ADDR_W-1:0] START_4K   = 15'h7000;
    localparam logic [ADDR_W-1:0] END_ADDR   = 15'h7fff;
    // cpu-mode base of the array; prom address 0000 is cpu address 8000
    localparam logic [15:0]       CPU_BASE   = 16'h8000;

    typedef enum logic [3:0] {
        ST_IDLE, ST_POWER, ST_FETCH, ST_WAIT, ST_SETUP, ST_PULSE,
        ST_HOLD, ST_TURN, ST_READ, ST_REDRIVE, ST_NEXT, ST_DONE
    } prog_state_t;

    typedef struct packed {
        prog_state_t         st;
        logic [1:0]          size;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [CNT_W-1:0]    cnt;
        logic [TRY_W-1:0]    tries;
        logic                pass2;
        logic                prom_on;
        logic                target_reset_n;
        logic                ce_n;
        logic                oe_n;
        logic                pgm_n;
        logic                d_oe;
        logic [DATA_W-1:0]   d_out;
        logic                req;
        logic [15:0]         req_addr;
        logic                busy;
        logic                done;
        logic                fail;
        logic [ADDR_W-1:0]   fail_addr;
    } prog_regs_t;

    localparam prog_regs_t PROG_RESET = '{
        st: ST_IDLE, size: SIZE_32K, addr: '0, wdata: '0, cnt: '0, tries: '0,
        pass2: 1'b0, prom_on: 1'b0, target_reset_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
        pgm_n: 1'b1, d_oe: 1'b0, d_out: '0, req: 1'b0, req_addr: '0, busy: 1'b0,
        done: 1'b0, fail: 1'b0, fail_addr: '0
    };

    typedef struct packed {
        logic [DATA_W-1:0] s1;
        logic [DATA_W-1:0] s2;
        logic [DATA_W-1:0] s3;
    } sync_regs_t;

    localparam sync_regs_t SYNC_RESET = '{s1: '0, s2: '0, s3: '0};

endpackage

//--- core/otp_programmer.sv
/*
 * Parallel PROM-mode programmer for a microcontroller one-time program array:
 * applies mode-setting levels, writes each byte with verified strobe pulses,
 * then runs a second full read-back pass.
 * Assumes the board switches the programming supply from vpp_enable, and a user
 * that answers every data_req with one data_valid cycle on the same clock.
 */
`timescale 1ns/10ps
module otp_programmer
    import otp_prog_pkg::*;
#(
    parameter int unsigned MAX_TRIES = MAX_PULSES
)
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    // user side
    input  wire logic              start,
    input  wire logic [1:0]        image_size,
    output      logic              data_req,
    output      logic [15:0]       data_addr,
    input  wire logic              data_valid,
    input  wire logic [DATA_W-1:0] data_in,
    output      logic              busy,
    output      logic              done,
    output      logic              fail,
    output      logic [ADDR_W-1:0] fail_addr,
    // target pins
    output      logic [7:0]        port7_pins,
    output      logic [7:0]        port1_pins,
    input  wire logic [DATA_W-1:0] port4_in,
    output      logic [DATA_W-1:0] port4_out,
    output      logic              port4_oe,
    output      logic              chip_sel_n,
    output      logic              out_gate_n,
    output      logic              write_pulse_strobe_n,
    output      logic              vpp_enable,
    output      logic              analog_supply_pin,
    output      logic              port2_bit1,
    output      logic              port6_bit1,
    output      logic              analog_reference_pin,
    output      logic              port2_bit2,
    output      logic              port2_bit0,
    output      logic              port6_bit0,
    output      logic              target_reset_n
);
    // refuse settings that the try counter or the shared timer cannot hold
    if (MAX_TRIES < 1 || MAX_TRIES > (2 ** TRY_W) - 1) begin : g_bad_tries
        $error("MAX_TRIES out of range");
    end
    if (PULSE_CYC >= (2 ** CNT_W) || MODE_CYC >= (2 ** CNT_W)) begin : g_bad_cnt
        $error("timing count does not fit the timer");
    end
    if (SETTLE_CYC < 4) begin : g_bad_settle
        // the three-stage sampler needs this long to show a fresh byte
        $error("settle time shorter than the pin sampler");
    end


    // timer loads; all fit CNT_W, pulse and mode counts refused above otherwise
    localparam logic [CNT_W-1:0] C_PULSE  = CNT_W'(PULSE_CYC);
    localparam logic [CNT_W-1:0] C_SETTLE = CNT_W'(SETTLE_CYC);
    localparam logic [CNT_W-1:0] C_MODE   = CNT_W'(MODE_CYC);
    localparam logic [TRY_W-1:0] T_MAX    = TRY_W'(MAX_TRIES);

    prog_regs_t q;
    prog_regs_t next_q;
    logic       cnt_zero;
    logic       match;

    // data pins come from the target, not from this clock domain
    pin_sample_if smp ();

    pin_sync3 u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .raw     (port4_in),
        .smp     (smp)
    );

    assign cnt_zero = (q.cnt == '0);
    // compare against the byte this address is meant to hold
    assign match    = (smp.value == q.wdata);

    function automatic logic [ADDR_W-1:0] start_of(input logic [1:0] sz);
        logic [ADDR_W-1:0] a;
        // only the image's own range is touched
        case (sz)
            SIZE_16K: a = START_16K;
            SIZE_8K:  a = START_8K;
            SIZE_4K:  a = START_4K;
            default:  a = START_32K;
        endcase
        return a;
    endfunction

    always_comb begin
        next_q     = q;
        next_q.req = 1'b0;
        if (!cnt_zero) begin
            next_q.cnt = q.cnt - CNT_W'(1);
        end
        case (q.st)
            ST_IDLE: begin
                // start while busy is ignored: only this state looks at it
                if (start) begin
                    next_q.size           = image_size;
                    next_q.addr           = start_of(image_size);
                    next_q.pass2          = 1'b0;
                    next_q.busy           = 1'b1;
                    next_q.done           = 1'b0;
                    next_q.fail           = 1'b0;
                    next_q.prom_on        = 1'b1;
                    next_q.target_reset_n = 1'b0;
                    next_q.cnt            = C_MODE;
                    next_q.st             = ST_POWER;
                end
            end
            ST_POWER: begin
                if (cnt_zero) begin
                    next_q.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // prom 0000-7fff sits at cpu 8000-ffff
                // relocate prom address to image address
                next_q.req      = 1'b1;
                next_q.req_addr = CPU_BASE | {1'b0, q.addr};
                next_q.st       = ST_WAIT;
            end
            ST_WAIT: begin
                // data_valid outside this state is dropped; one request in flight
                if (data_valid) begin
                    next_q.wdata = data_in;
                    next_q.ce_n  = 1'b0;
                    next_q.tries = '0;
                    next_q.cnt   = C_SETTLE;
                    if (q.pass2) begin
                        next_q.st = ST_TURN;
                    end else begin
                        next_q.d_out = data_in;
                        next_q.d_oe  = 1'b1;
                        next_q.st    = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_zero) begin
                    next_q.pgm_n = 1'b0;
                    next_q.cnt   = C_PULSE;
                    next_q.tries = q.tries + TRY_W'(1);
                    next_q.st    = ST_PULSE;
                end
            end
            ST_PULSE: begin
                // data and address stay put until after the strobe rises
                if (cnt_zero) begin
                    next_q.pgm_n = 1'b1;
                    next_q.cnt   = C_SETTLE;
                    next_q.st    = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // release bus before gate goes low
                if (cnt_zero) begin
                    next_q.d_oe = 1'b0;
                    next_q.cnt  = C_SETTLE;
                    next_q.st   = ST_TURN;
                end
            end
            ST_TURN: begin
                if (cnt_zero) begin
                    // select and gate low, strobe high
                    next_q.oe_n = 1'b0;
                    next_q.cnt  = C_SETTLE;
                    next_q.st   = ST_READ;
                end
            end
            ST_READ: begin
                // never compare a byte that is still moving through the sampler
                if (cnt_zero && smp.steady) begin
                    next_q.oe_n = 1'b1;
                    next_q.cnt  = C_SETTLE;
                    next_q.st   = ST_NEXT;
                    if (!match) begin
                        // first pass retries until limit; a read-back miss or the last try logs and moves on
                        if (q.pass2 || q.tries >= T_MAX) begin
                            if (!q.fail) begin
                                next_q.fail_addr = q.addr;
                            end
                            next_q.fail = 1'b1;
                        end else begin
                            next_q.st = ST_REDRIVE;
                        end
                    end
                end
            end
            ST_REDRIVE: begin
                // target output must be off before we drive again
                if (cnt_zero) begin
                    next_q.d_oe = 1'b1;
                    next_q.cnt  = C_SETTLE;
                    next_q.st   = ST_SETUP;
                end
            end
            ST_NEXT: begin
                if (cnt_zero) begin
                    next_q.ce_n = 1'b1;
                    next_q.st   = ST_FETCH;
                    if (q.addr == END_ADDR) begin
                        if (q.pass2) begin
                            next_q.st = ST_DONE;
                        end else begin
                            next_q.pass2 = 1'b1;
                            next_q.addr  = start_of(q.size);
                        end
                    end else begin
                        next_q.addr = q.addr + ADDR_W'(1);
                    end
                end
            end
            ST_DONE: begin
                // a failed job still runs to the end; fail and fail_addr report it
                // mode pin back low
                next_q.prom_on        = 1'b0;
                next_q.target_reset_n = 1'b1;
                next_q.busy           = 1'b0;
                next_q.done           = 1'b1;
                next_q.st             = ST_IDLE;
            end
            default: begin
                next_q = PROG_RESET;
            end
        endcase
    end

    // one register for all state; every output below is one of its bits or tied low
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= PROG_RESET;
        end else begin
            q <= next_q;
        end
    end

    // plain logic levels on the address pins, no signature cycle
    // high byte on port7, low byte reversed on port1
    assign port7_pins = {1'b0, q.addr[14:8]};
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            port1_pins[i] = q.addr[7-i];
        end
    end

    assign chip_sel_n           = q.ce_n;
    assign out_gate_n           = q.oe_n;
    assign write_pulse_strobe_n = q.pgm_n;
    assign port4_out            = q.d_out;
    assign port4_oe             = q.d_oe;
    // mode pin high only while programming
    assign vpp_enable           = q.prom_on;
    assign analog_supply_pin    = q.prom_on;
    assign port2_bit1           = q.prom_on;
    assign port6_bit1           = q.prom_on;
    // setting pins low; no flop ever sets them
    assign analog_reference_pin = q.target_reset_n & ~q.target_reset_n;
    assign port2_bit2           = analog_reference_pin;
    assign port2_bit0           = analog_reference_pin;
    assign port6_bit0           = analog_reference_pin;
    assign target_reset_n       = q.target_reset_n;
    assign data_req             = q.req;
    assign data_addr            = q.req_addr;
    assign busy                 = q.busy;
    assign done                 = q.done;
    assign fail                 = q.fail;
    assign fail_addr            = q.fail_addr;
endmodule

//--- core/pin_sample_if.sv
/*
 * Carries the synchronised data-pin byte from the sampler to the sequencer.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/10ps
interface pin_sample_if;
    import otp_prog_pkg::*;
    logic [DATA_W-1:0] value;
    logic              steady;
    modport src (output value, output steady);
    modport dst (input value, input steady);
endinterface

//--- core/pin_sync3.sv
/*
 * Three-stage sampler for the target's data pins.
 * Assumes raw pins are asynchronous to clk_sys; steady means stages two and three agree.
 */
`timescale 1ns/10ps
module pin_sync3
    import otp_prog_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic [DATA_W-1:0] raw,
    pin_sample_if.src              smp
);
    sync_regs_t q;
    sync_regs_t next_q;

    always_comb begin
        next_q    = q;
        next_q.s1 = raw;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= SYNC_RESET;
        end else begin
            q <= next_q;
        end
    end

    // first stage feeds only the second stage
    assign smp.value  = q.s3;
    assign smp.steady = (q.s2 == q.s3);
endmodule

//--- verif/otp_programmer_properties.sv
/*
 * Concurrent checks on the programmer's target pins and user port.
 * Assumes one clock, clk_sys, and srst synchronous active high.
 */
`timescale 1ns/10ps
module otp_programmer_properties
    import otp_prog_pkg::*;
#(
    parameter int unsigned MAX_TRIES = MAX_PULSES
)
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        data_req,
    input wire logic [15:0] data_addr,
    input wire logic        busy,
    input wire logic [7:0]  port7_pins,
    input wire logic [7:0]  port1_pins,
    input wire logic [7:0]  port4_out,
    input wire logic        port4_oe,
    input wire logic        chip_sel_n,
    input wire logic        out_gate_n,
    input wire logic        write_pulse_strobe_n,
    input wire logic        vpp_enable,
    input wire logic        analog_supply_pin,
    input wire logic        port2_bit1,
    input wire logic        port6_bit1,
    input wire logic        analog_reference_pin,
    input wire logic        port2_bit2,
    input wire logic        port2_bit0,
    input wire logic        port6_bit0,
    input wire logic        target_reset_n
);
    logic [11:0] low_cnt;
    logic [4:0]  tries;
    logic [7:0]  lo;

    assign lo = {<<{port1_pins}};
    // counts strobe-low cycles and strobes since the last request
    always_ff @(posedge clk_sys) begin
        if (srst || write_pulse_strobe_n)
            low_cnt <= 12'h000;
        else
            low_cnt <= low_cnt + 12'h001;
        if (srst || data_req)
            tries <= 5'h00;
        else if (!write_pulse_strobe_n && low_cnt == 12'h000)
            tries <= tries + 5'h01;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_strobe_start;
        $fell(write_pulse_strobe_n);
    endsequence
    sequence s_read_start;
        $fell(out_gate_n);
    endsequence
    sequence s_select;
        $fell(chip_sel_n);
    endsequence

    mode_pins_a: assert property (
        busy |-> vpp_enable && analog_supply_pin && port2_bit1 && port6_bit1 && !target_reset_n)
        else $error("setting pins wrong while busy");
    ground_pins_a: assert property (
        !(analog_reference_pin || port2_bit2 || port2_bit0 || port6_bit0))
        else $error("low setting pin driven high");
    no_fight_a: assert property (
        port4_oe |-> out_gate_n)
        else $error("host drives data while gate low");
    pulse_width_a: assert property (
        $rose(write_pulse_strobe_n) |-> low_cnt >= PULSE_CYC && low_cnt <= PULSE_CYC + 1)
        else $error("strobe width off");
    strobe_hold_a: assert property (
        !write_pulse_strobe_n |-> port4_oe && !chip_sel_n && out_gate_n && $stable(port4_out)
            && $stable(port1_pins) && $stable(port7_pins))
        else $error("pins moved during strobe");
    strobe_setup_a: assert property (
        s_strobe_start |-> $past(port4_oe, 8) && $past(port4_out, 8) == port4_out)
        else $error("data not set up before strobe");
    addr_match_a: assert property (
        s_select |-> {port7_pins[6:0], lo} == data_addr[14:0] && !port7_pins[7])
        else $error("address pins differ from request");
    req_map_a: assert property (
        data_req |-> data_addr[15] ##1 !data_req)
        else $error("request not a cpu-map single pulse");
    read_gate_a: assert property (
        s_read_start |-> !chip_sel_n && !port4_oe && write_pulse_strobe_n)
        else $error("read started with bad controls");
    retry_bound_a: assert property (
        tries <= MAX_TRIES)
        else $error("too many strobes on one address");
endmodule

bind otp_programmer otp_programmer_properties #(.MAX_TRIES(MAX_TRIES)) u_props (.*);

//--- verif/otp_programmer_tb_top.sv
/*
 * Self-checking bench: programmer against a behavioural one-time array.
 * Assumes a whole job is too long to run, so jobs are cut short by reset or by the end of the run.
 */
`timescale 1ns/10ps
module otp_programmer_tb_top
    import otp_prog_pkg::*;
;
    localparam int unsigned TRIES = 2;
    logic        clk_sys, srst, start, data_valid, data_req, busy, done, fail, mode_ok;
    logic        port4_oe, chip_sel_n, out_gate_n, write_pulse_strobe_n, vpp_enable;
    logic        analog_supply_pin, port2_bit1, port6_bit1, analog_reference_pin;
    logic        port2_bit2, port2_bit0, port6_bit0, target_reset_n;
    logic [1:0]  image_size;
    logic [7:0]  data_in, port7_pins, port1_pins, port4_in, port4_out;
    logic [15:0] data_addr;
    logic [14:0] fail_addr;
    logic [15:0] starts [4] = '{16'h8000, 16'hc000, 16'he000, 16'hf000};
    logic [7:0]  img [int];
    int          exp_q [$];
    int          err_total, n_tests;

    otp_programmer #(.MAX_TRIES(TRIES)) dut (.*);
    otp_target_model tgt (.*);

    // array answers only at PROM-mode levels, target held in reset
    assign mode_ok = vpp_enable && analog_supply_pin && port2_bit1 && port6_bit1
                     && !target_reset_n
                     && !(analog_reference_pin || port2_bit2 || port2_bit0 || port6_bit0);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("%0d mismatches in %0d comparisons", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic kick(input logic [1:0] size);
        image_size = size;
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask

    task automatic do_reset;
        srst = 1'b1;
        tick(4);
        srst = 1'b0;
        check({chip_sel_n, out_gate_n, write_pulse_strobe_n, port4_oe, vpp_enable,
               target_reset_n, busy, done, fail, data_req}, 10'h390);
    endtask

    // bounded wait: a full retry cycle is well under 6000 clocks
    task automatic wait_req(input logic [15:0] exp);
        int k = 0;
        while (data_req !== 1'b1 && k < 6000) begin
            tick(1);
            k++;
        end
        check({data_req, data_addr}, {1'b1, exp});
    endtask

    task automatic serve(input logic [14:0] a);
        wait_req({1'b1, a});
        data_valid = 1'b1;
        data_in = img[a];
        tick(1);
        data_valid = 1'b0;
    endtask

    initial begin
        #(60000 * 50);
        err_total++;
        test_done();
    end

    initial begin
        srst = 1'b1;
        start = 1'b0;
        image_size = 2'h0;
        data_valid = 1'b0;
        data_in = 8'h00;
        err_total = 0;
        n_tests = 0;
        void'($urandom(32'hb210));
        for (int s = 0; s < 4; s++) begin
            do_reset();
            kick(2'(s));
            check({busy, vpp_enable, target_reset_n, done}, 4'hc);
            wait_req(starts[s]);
        end
        do_reset();
        for (int a = 'h7000; a < 'h7005; a++) begin
            img[a] = 8'($urandom);
            exp_q.push_back(a);
        end
        img['h7001] = 8'h5a;
        img['h7002] = 8'h00;
        tgt.need['h7001] = 2;
        tgt.need['h7002] = 99;
        kick(2'h3);
        serve(15'(exp_q.pop_front()));
        check(mode_ok, 1);
        // a second start mid-job must be ignored
        kick(2'h0);
        while (exp_q.size() > 0)
            serve(15'(exp_q.pop_front()));
        for (int a = 'h7000; a < 'h7004; a++)
            check(tgt.mem[a], (a == 'h7002) ? 8'hff : img[a]);
        check(tgt.hits['h7001], 2);
        check(tgt.hits['h7002], TRIES);
        check({fail, fail_addr}, {1'b1, 15'h7002});
        check({busy, done, vpp_enable}, 3'h5);
        test_done();
    end
endmodule

//--- verif/otp_target_model.sv
/*
 * Behavioural one-time array seen through its PROM-mode pins.
 * Assumes the bench works out mode_ok from the setting pins.
 */
`timescale 1ns/10ps
module otp_target_model
    import otp_prog_pkg::*;
(
    input  wire logic [7:0] port7_pins,
    input  wire logic [7:0] port1_pins,
    input  wire logic [7:0] port4_out,
    input  wire logic       port4_oe,
    input  wire logic       chip_sel_n,
    input  wire logic       out_gate_n,
    input  wire logic       write_pulse_strobe_n,
    input  wire logic       mode_ok,
    output      logic [7:0] port4_in
);
    // the 1 KB data RAM is separate and never answers on these pins
    // 32 KB array at 0000-7fff in this mode
    logic [7:0]  mem  [0:32767];
    int          hits [0:32767];
    int          need [0:32767];
    logic [7:0]  lo;
    logic [14:0] addr;
    logic [7:0]  last;
    logic        drive;

    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (hits[i]) hits[i] = 0;
        foreach (need[i]) need[i] = 1;
        last = 8'h00;
    end
    // high byte on port 7, low byte reversed on port 1
    assign lo = {<<{port1_pins}};
    assign addr = {port7_pins[6:0], lo};
    // plain array read, no identification mode
    assign drive = mode_ok && !chip_sel_n && !out_gate_n && write_pulse_strobe_n;
    // released bus shows the inverse of its last value, never a kind guess
    assign port4_in = port4_oe ? port4_out : (drive ? mem[addr] : ~last);
    always @(port4_oe or drive or port4_out or addr) begin
        if (port4_oe)
            last = port4_out;
        else if (drive)
            last = mem[addr];
    end
    // weak cells take several strobes before the byte lands
    always @(negedge write_pulse_strobe_n) begin
        if (mode_ok && !chip_sel_n && out_gate_n && port4_oe) begin
            hits[addr] = hits[addr] + 1;
            if (hits[addr] >= need[addr])
                mem[addr] = mem[addr] & port4_out;
        end
    end
endmodule
